// ===== rtl/urb_pkg.sv
// shared constants and carrier types of the uart reset / baud divisor block
// assumes a single sys_clk domain and an AXI4-Lite master on the register side
package urb_pkg;
   // register word index, byte address is four times the index
   localparam logic [3:0] URB_IDX_DATA = 4'h0;
   localparam logic [3:0] URB_IDX_IER = 4'h1;
   localparam logic [3:0] URB_IDX_ISR = 4'h2;
   localparam logic [3:0] URB_IDX_LCR = 4'h3;
   localparam logic [3:0] URB_IDX_MCR = 4'h4;
   localparam logic [3:0] URB_IDX_LSR = 4'h5;
   localparam logic [3:0] URB_IDX_MSR = 4'h6;
   localparam logic [3:0] URB_IDX_SCR = 4'h7;
   localparam logic [3:0] URB_IDX_STAT = 4'h8;
   localparam logic [3:0] URB_IDX_MASK = 4'h9;
   // line format bits
   localparam int URB_LCR_STOP2 = 2;
   localparam int URB_LCR_PAREN = 3;
   localparam int URB_LCR_EVEN = 4;
   localparam int URB_LCR_STICK = 5;
   localparam int URB_LCR_BREAK = 6;
   localparam int URB_LCR_DLAB = 7;
   // modem output control bits
   localparam int URB_MCR_DTR = 0;
   localparam int URB_MCR_RTS = 1;
   localparam int URB_MCR_SOFT = 2;
   localparam int URB_MCR_INTEN = 3;
   // interrupt enable bits
   localparam int URB_IER_THRE = 1;
   localparam int URB_IER_MODEM = 3;
   // reset and status values
   localparam logic [7:0] URB_REG_RESET = 8'h00;
   localparam logic [7:0] URB_LSR_RESET = 8'h60;
   localparam logic [7:0] URB_ISR_NONE = 8'h01;
   localparam logic [7:0] URB_ISR_THRE = 8'h02;
   localparam logic [7:0] URB_ISR_MODEM = 8'h00;
   localparam logic [7:0] URB_BYTE_ONES = 8'hFF;
   localparam logic [15:0] URB_DIV_RESET = 16'h0000;
   // start delay in baud (16x) ticks, and bit phase
   localparam logic [4:0] URB_TX_START_MIN = 5'h08;
   localparam logic [4:0] URB_TX_START_MAX = 5'h18;
   localparam logic [3:0] URB_PHASE_LAST = 4'hF;
   // sticky event bits
   localparam int URB_EV_THRE = 0;
   localparam int URB_EV_TXDONE = 1;
   localparam int URB_EV_MODEM = 2;
   localparam int URB_EV_W = 3;
   localparam logic [1:0] URB_RESP_OKAY = 2'h0;
   localparam logic [1:0] URB_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0]
   {
      URB_TX_IDLE = 3'h0,
      URB_TX_START = 3'h1,
      URB_TX_DATA = 3'h3,
      URB_TX_PAR = 3'h2,
      URB_TX_STOP = 3'h6
   } urb_tx_state_t;

   typedef struct packed
   {
      logic awvalid; logic [5:0] awaddr; logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
      logic bready; logic arvalid; logic [5:0] araddr; logic rready;
   } urb_axi_req_t;

   typedef struct packed
   {
      logic awready; logic wready; logic bvalid; logic [1:0] bresp;
      logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
   } urb_axi_rsp_t;

   typedef struct packed
   {
      logic ctsN; logic dsrN; logic riN; logic dcdN;
   } urb_modem_in_t;
endpackage

// ===== rtl/urb_uart.sv
// uart core: reset defaults, 16x baud divisor, transmitter, modem status, AXI4-Lite slave
// assumes modem inputs already synchronous to sys_clk; receiver path is not present
`timescale 1ns/1ps
// Function
// - baud tick rate is input clock over divisor; one serial bit is sixteen ticks
// - reset drives serial out, soft reset, request and ready outputs high, interrupt floated
// - interrupt source register reads one in bit 0, zeros above after reset
// - line state reads bits 5 and 6 set, others clear after reset
// - modem change bits clear on reset, upper bits follow modem inputs
// - start bit begins 8 to 24 baud ticks after a character write
// - divisor latch replaces data and enable registers while line format bit 7 set
// - interrupt pin driven only while modem control bit 3 is one
module urb_uart
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // register bus
   input wire urb_pkg::urb_axi_req_t axiReq,
   output urb_pkg::urb_axi_rsp_t axiRsp,
   // modem and serial pins
   input wire urb_pkg::urb_modem_in_t modemIn,
   output logic txd,
   output logic rtsN,
   output logic dtrN,
   output logic softRstOut,
   // uart interrupt pin, enable low while driven
   output logic uartInt,
   output logic uartIntOeN,
   // system interrupt
   output logic irq
);
   logic awready, wready, bvalid, arready, rvalid, awHave, wHave;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [3:0] awIdx;
   logic [7:0] wByte;
   logic wLane0;
   logic [7:0] interrupt_enable_reg, line_format_reg, modem_output_ctrl_reg, fifo_ctrl_reg, scr, hold;
   logic [15:0] divisor, divCnt;
   logic baudTick, holdFull, threPend, primed;
   logic [3:0] phase, msrDelta, modemPrev;
   logic [4:0] waitCnt;
   urb_pkg::urb_tx_state_t txState, next_txState;
   logic [7:0] shifter;
   logic [2:0] bitCnt;
   logic txPar, stopCnt, txLine;
   logic [urb_pkg::URB_EV_W-1:0] irqStat, irqMask, evSet;
   logic [7:0] isrVal, lsrVal, msrVal, rdMux;

   function automatic logic [3:0] regIdx(input logic [5:0] addr);
      regIdx = addr[5:2];
   endfunction

   function automatic logic isMapped(input logic [3:0] idx);
      isMapped = (idx <= urb_pkg::URB_IDX_MASK);
   endfunction

   assign axiRsp = '{awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp};

   // write channel decode, address and data may come in either order
   wire doWrite = awHave && wHave && !bvalid;
   wire wrEn = doWrite && wLane0 && isMapped(awIdx);
   wire dlab = line_format_reg[urb_pkg::URB_LCR_DLAB];
   wire wrThr = wrEn && awIdx == urb_pkg::URB_IDX_DATA && !dlab;
   wire wrDll = wrEn && awIdx == urb_pkg::URB_IDX_DATA && dlab;
   wire wrDlm = wrEn && awIdx == urb_pkg::URB_IDX_IER && dlab;
   wire rdTake = axiReq.arvalid && arready;
   wire [3:0] rdIdx = regIdx(axiReq.araddr);
   wire rdIsr = rdTake && rdIdx == urb_pkg::URB_IDX_ISR;
   wire rdMsr = rdTake && rdIdx == urb_pkg::URB_IDX_MSR;
   wire rdStat = rdTake && rdIdx == urb_pkg::URB_IDX_STAT;

   // AXI write side: each channel latches once; the write fires only when both are held,
   // so the idle state after reset can never be mistaken for a finished transfer
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= urb_pkg::URB_RESP_OKAY;
         awIdx <= urb_pkg::URB_IDX_DATA;
         wByte <= urb_pkg::URB_REG_RESET;
         wLane0 <= 1'b0;
         awHave <= 1'b0;
         wHave <= 1'b0;
      end
      else
      begin
         if (awready && axiReq.awvalid)
         begin
            awready <= 1'b0;
            awHave <= 1'b1;
            awIdx <= regIdx(axiReq.awaddr);
         end
         else if (!awHave)
            awready <= 1'b1;
         if (wready && axiReq.wvalid)
         begin
            wready <= 1'b0;
            wHave <= 1'b1;
            wByte <= axiReq.wdata[7:0];
            wLane0 <= axiReq.wstrb[0];
         end
         else if (!wHave)
            wready <= 1'b1;
         if (doWrite)
         begin
            awHave <= 1'b0;
            wHave <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b1;
            bresp <= isMapped(awIdx) ? urb_pkg::URB_RESP_OKAY : urb_pkg::URB_RESP_SLVERR;
         end
         else if (bvalid && axiReq.bready)
            bvalid <= 1'b0;
      end
   end

   // AXI read side, one read outstanding, answer one cycle after acceptance
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= urb_pkg::URB_RESP_OKAY;
      end
      else if (rdTake)
      begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= {24'h00_0000, rdMux};
         rresp <= isMapped(rdIdx) ? urb_pkg::URB_RESP_OKAY : urb_pkg::URB_RESP_SLVERR;
      end
      else if (rvalid && axiReq.rready)
      begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
      else if (!rvalid)
         arready <= 1'b1;
   end

   // control registers, cleared by reset
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         interrupt_enable_reg <= urb_pkg::URB_REG_RESET;
         line_format_reg <= urb_pkg::URB_REG_RESET;
         modem_output_ctrl_reg <= urb_pkg::URB_REG_RESET;
         fifo_ctrl_reg <= urb_pkg::URB_REG_RESET;
         scr <= urb_pkg::URB_REG_RESET;
         irqMask <= '0;
      end
      else if (wrEn)
      begin
         case (awIdx)
            urb_pkg::URB_IDX_IER: if (!dlab) interrupt_enable_reg <= wByte;
            urb_pkg::URB_IDX_ISR: fifo_ctrl_reg <= wByte;
            urb_pkg::URB_IDX_LCR: line_format_reg <= wByte;
            urb_pkg::URB_IDX_MCR: modem_output_ctrl_reg <= wByte;
            urb_pkg::URB_IDX_SCR: scr <= wByte;
            urb_pkg::URB_IDX_MASK: irqMask <= wByte[urb_pkg::URB_EV_W-1:0];
            default: scr <= scr;
         endcase
      end
   end

   // divisor latch; cleared to zero by reset, which holds the baud generator still
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         divisor <= urb_pkg::URB_DIV_RESET;
      else if (wrDll)
         divisor[7:0] <= wByte;
      else if (wrDlm)
         divisor[15:8] <= wByte;
   end

   // 16x baud tick: one pulse every divisor clocks; a divisor write restarts the count,
   // otherwise a stale count from a large old divisor would delay the new rate
   always_ff @(posedge sys_clk)
   begin
      if (rst || divisor == urb_pkg::URB_DIV_RESET || wrDll || wrDlm)
      begin
         divCnt <= urb_pkg::URB_DIV_RESET;
         baudTick <= 1'b0;
      end
      else if (divCnt == urb_pkg::URB_DIV_RESET)
      begin
         divCnt <= divisor - 16'h0001;
         baudTick <= 1'b1;
      end
      else
      begin
         divCnt <= divCnt - 16'h0001;
         baudTick <= 1'b0;
      end
   end

   // free running bit phase; a bit lasts sixteen ticks
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         phase <= 4'h0;
      else if (baudTick)
         phase <= phase + 4'h1;
   end

   // start gate: at least 8 ticks since the write, then the next phase wrap (at most 24)
   wire startGo = txState == urb_pkg::URB_TX_IDLE && holdFull && baudTick
                  && waitCnt >= urb_pkg::URB_TX_START_MIN && phase == urb_pkg::URB_PHASE_LAST;
   wire bitEnd = baudTick && phase == urb_pkg::URB_PHASE_LAST;
   wire [2:0] lastBit = {1'b1, line_format_reg[1:0]};

   always_ff @(posedge sys_clk)
   begin
      if (rst || wrThr)
         waitCnt <= 5'h00;
      else if (baudTick && waitCnt < urb_pkg::URB_TX_START_MIN)
         waitCnt <= waitCnt + 5'h01;
   end

   // holding register and its empty flag
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         hold <= urb_pkg::URB_REG_RESET;
         holdFull <= 1'b0;
      end
      else if (wrThr)
      begin
         hold <= wByte;
         holdFull <= 1'b1;
      end
      else if (startGo)
         holdFull <= 1'b0;
   end

   // transmit sequencer
   always_comb
   begin
      next_txState = txState;
      case (txState)
         urb_pkg::URB_TX_IDLE: if (startGo) next_txState = urb_pkg::URB_TX_START;
         urb_pkg::URB_TX_START: if (bitEnd) next_txState = urb_pkg::URB_TX_DATA;
         urb_pkg::URB_TX_DATA:
            if (bitEnd && bitCnt == lastBit)
               next_txState = line_format_reg[urb_pkg::URB_LCR_PAREN] ? urb_pkg::URB_TX_PAR : urb_pkg::URB_TX_STOP;
         urb_pkg::URB_TX_PAR: if (bitEnd) next_txState = urb_pkg::URB_TX_STOP;
         urb_pkg::URB_TX_STOP:
            if (bitEnd && (stopCnt || !line_format_reg[urb_pkg::URB_LCR_STOP2])) next_txState = urb_pkg::URB_TX_IDLE;
         default: next_txState = urb_pkg::URB_TX_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         txState <= urb_pkg::URB_TX_IDLE;
      else
         txState <= next_txState;
   end

   // shifter, bit counter and parity, loaded from the holding register
   wire [7:0] dataMask = urb_pkg::URB_BYTE_ONES >> (2'h3 - line_format_reg[1:0]);
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         shifter <= urb_pkg::URB_REG_RESET;
         bitCnt <= 3'h0;
         txPar <= 1'b0;
         stopCnt <= 1'b0;
      end
      else if (startGo)
      begin
         shifter <= hold & dataMask;
         bitCnt <= 3'h0;
         stopCnt <= 1'b0;
         // stick parity forces the inverse of the even bit
         txPar <= line_format_reg[urb_pkg::URB_LCR_STICK] ? !line_format_reg[urb_pkg::URB_LCR_EVEN]
                  : ((^(hold & dataMask)) ^ !line_format_reg[urb_pkg::URB_LCR_EVEN]);
      end
      else if (bitEnd && txState == urb_pkg::URB_TX_DATA)
      begin
         shifter <= {1'b0, shifter[7:1]};
         bitCnt <= bitCnt + 3'h1;
      end
      else if (bitEnd && txState == urb_pkg::URB_TX_STOP)
         stopCnt <= 1'b1;
   end

   always_comb
   begin
      case (txState)
         urb_pkg::URB_TX_START: txLine = 1'b0;
         urb_pkg::URB_TX_DATA: txLine = shifter[0];
         urb_pkg::URB_TX_PAR: txLine = txPar;
         default: txLine = 1'b1;
      endcase
   end

   // serial and modem outputs; reset forces mark, soft reset high and inactive levels elsewhere
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         txd <= 1'b1;
         rtsN <= 1'b1;
         dtrN <= 1'b1;
         softRstOut <= 1'b1;
         uartIntOeN <= 1'b1;
         uartInt <= 1'b0;
      end
      else
      begin
         txd <= txLine && !line_format_reg[urb_pkg::URB_LCR_BREAK];
         rtsN <= !modem_output_ctrl_reg[urb_pkg::URB_MCR_RTS];
         dtrN <= !modem_output_ctrl_reg[urb_pkg::URB_MCR_DTR];
         softRstOut <= modem_output_ctrl_reg[urb_pkg::URB_MCR_SOFT];
         uartIntOeN <= !modem_output_ctrl_reg[urb_pkg::URB_MCR_INTEN];
         uartInt <= isrVal != urb_pkg::URB_ISR_NONE;
      end
   end

   // modem change detection; set wins over the read clear
   wire [3:0] modemNow = {modemIn.dcdN, modemIn.riN, modemIn.dsrN, modemIn.ctsN};
   wire [3:0] modemChg = primed ? {modemNow[3] ^ modemPrev[3], modemNow[2] & !modemPrev[2],
                                   modemNow[1:0] ^ modemPrev[1:0]} : 4'h0;
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         msrDelta <= 4'h0;
         modemPrev <= 4'hF;
         primed <= 1'b0;
      end
      else
      begin
         modemPrev <= modemNow;
         primed <= 1'b1;
         msrDelta <= (rdMsr ? 4'h0 : msrDelta) | modemChg;
      end
   end

   // holding-empty source: set on transfer to the shifter, cleared by a write or a source read
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         threPend <= 1'b0;
      else if (startGo)
         threPend <= 1'b1;
      else if (wrThr || (rdIsr && isrVal == urb_pkg::URB_ISR_THRE))
         threPend <= 1'b0;
   end

   // status views
   always_comb
   begin
      if (threPend && interrupt_enable_reg[urb_pkg::URB_IER_THRE])
         isrVal = urb_pkg::URB_ISR_THRE;
      else if (|msrDelta && interrupt_enable_reg[urb_pkg::URB_IER_MODEM])
         isrVal = urb_pkg::URB_ISR_MODEM;
      else
         isrVal = urb_pkg::URB_ISR_NONE;
      lsrVal = {1'b0, !holdFull && txState == urb_pkg::URB_TX_IDLE, !holdFull, 5'h00};
      msrVal = {~modemNow, msrDelta};
   end

   // read mux; divisor bytes replace data and enable while the latch is selected
   always_comb
   begin
      case (rdIdx)
         urb_pkg::URB_IDX_DATA: rdMux = dlab ? divisor[7:0] : urb_pkg::URB_REG_RESET;
         urb_pkg::URB_IDX_IER: rdMux = dlab ? divisor[15:8] : interrupt_enable_reg;
         urb_pkg::URB_IDX_ISR: rdMux = isrVal;
         urb_pkg::URB_IDX_LCR: rdMux = line_format_reg;
         urb_pkg::URB_IDX_MCR: rdMux = modem_output_ctrl_reg;
         urb_pkg::URB_IDX_LSR: rdMux = lsrVal;
         urb_pkg::URB_IDX_MSR: rdMux = msrVal;
         urb_pkg::URB_IDX_SCR: rdMux = scr;
         urb_pkg::URB_IDX_STAT: rdMux = {5'h00, irqStat};
         urb_pkg::URB_IDX_MASK: rdMux = {5'h00, irqMask};
         default: rdMux = urb_pkg::URB_REG_RESET;
      endcase
   end

   // sticky events, cleared by reading; an event in the read cycle survives
   always_comb
   begin
      evSet = '0;
      evSet[urb_pkg::URB_EV_THRE] = startGo;
      evSet[urb_pkg::URB_EV_TXDONE] = txState == urb_pkg::URB_TX_STOP && next_txState == urb_pkg::URB_TX_IDLE;
      evSet[urb_pkg::URB_EV_MODEM] = |modemChg;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         irqStat <= '0;
         irq <= 1'b0;
      end
      else
      begin
         irqStat <= (rdStat ? '0 : irqStat) | evSet;
         irq <= |(irqStat & irqMask);
      end
   end

   // checks
   logic [15:0] gapCnt;
   logic divChg, seenTick;
   logic [4:0] wrTicks;
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         gapCnt <= 16'h0000;
         divChg <= 1'b1;
         seenTick <= 1'b0;
         wrTicks <= 5'h00;
      end
      else
      begin
         gapCnt <= baudTick ? 16'h0000 : gapCnt + 16'h0001;
         divChg <= (wrDll || wrDlm) ? 1'b1 : (baudTick ? 1'b0 : divChg);
         seenTick <= seenTick || baudTick;
         wrTicks <= wrThr ? 5'h00 : ((baudTick && wrTicks != 5'h1F) ? wrTicks + 5'h01 : wrTicks);
      end
   end

   baud_gap_a: assert property (@(posedge sys_clk) disable iff (rst) baudTick && seenTick && !divChg |-> gapCnt == divisor - 16'h0001) else $error("baud tick spacing wrong");
   reset_pins_a: assert property (@(posedge sys_clk) rst |=> txd && rtsN && dtrN && softRstOut && uartIntOeN) else $error("pin reset state wrong");
   isr_reset_a: assert property (@(posedge sys_clk) rst |=> isrVal == urb_pkg::URB_ISR_NONE) else $error("isr reset value wrong");
   lsr_reset_a: assert property (@(posedge sys_clk) rst |=> lsrVal == urb_pkg::URB_LSR_RESET) else $error("lsr reset value wrong");
   msr_reset_a: assert property (@(posedge sys_clk) rst |=> msrVal == {~modemNow, 4'h0}) else $error("msr reset value wrong");
   tx_start_a: assert property (@(posedge sys_clk) disable iff (rst) $rose(txState == urb_pkg::URB_TX_START) |-> wrTicks >= urb_pkg::URB_TX_START_MIN && wrTicks <= urb_pkg::URB_TX_START_MAX) else $error("start bit delay out of range");
   ctrl_reset_a: assert property (@(posedge sys_clk) rst |=> interrupt_enable_reg == 8'h00 && line_format_reg == 8'h00 && modem_output_ctrl_reg == 8'h00 && fifo_ctrl_reg == 8'h00) else $error("control reset wrong");
   div_latch_a: assert property (@(posedge sys_clk) disable iff (rst) wrEn && awIdx == urb_pkg::URB_IDX_DATA |=> divisor[7:0] == ($past(dlab) ? $past(wByte) : $past(divisor[7:0]))) else $error("divisor latch access wrong");
   int_drive_a: assert property (@(posedge sys_clk) disable iff (rst) ##1 uartIntOeN == !$past(modem_output_ctrl_reg[urb_pkg::URB_MCR_INTEN], 1)) else $error("int pin enable wrong");
   div_write_c: cover property (@(posedge sys_clk) disable iff (rst) wrDll ##[1:50] wrDlm);
   tx_frame_c: cover property (@(posedge sys_clk) disable iff (rst) startGo ##[1:1000] evSet[urb_pkg::URB_EV_TXDONE]);
   modem_chg_c: cover property (@(posedge sys_clk) disable iff (rst) |modemChg ##1 rdMsr);
   irq_raise_c: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq));
endmodule

// ===== dv/urb_host_model.sv
// behavioural AXI4-Lite host that plays the processor side of the uart
// assumes one caller at a time; a hang is cut short by the bench watchdog
`timescale 1ns/1ps
module urb_host_model
(
   // clock
   input wire logic sys_clk,
   // register bus
   output urb_pkg::urb_axi_req_t axiReq,
   input wire urb_pkg::urb_axi_rsp_t axiRsp
);
   initial axiReq = '0;

   // address and data offered together, each released only at the edge that takes it
   task automatic wr(input logic [3:0] idx, input logic [7:0] d, output logic [1:0] resp);
      logic done;
      done = 1'b0;
      @(posedge sys_clk);
      axiReq.awvalid <= 1'b1;
      axiReq.awaddr <= {idx, 2'b00};
      axiReq.wvalid <= 1'b1;
      axiReq.wdata <= {24'h00_0000, d};
      axiReq.wstrb <= 4'hF;
      axiReq.bready <= 1'b1;
      while (!done)
      begin
         @(posedge sys_clk);
         if (axiReq.awvalid && axiRsp.awready)
            axiReq.awvalid <= 1'b0;
         if (axiReq.wvalid && axiRsp.wready)
            axiReq.wvalid <= 1'b0;
         done = (axiRsp.bvalid === 1'b1);
      end
      resp = axiRsp.bresp;
      axiReq.bready <= 1'b0;
   endtask

   // rready stays up from the start so the answer is taken at the edge it is seen
   task automatic rd(input logic [3:0] idx, output logic [31:0] d, output logic [1:0] resp);
      logic done;
      done = 1'b0;
      @(posedge sys_clk);
      axiReq.arvalid <= 1'b1;
      axiReq.araddr <= {idx, 2'b00};
      axiReq.rready <= 1'b1;
      while (!done)
      begin
         @(posedge sys_clk);
         if (axiReq.arvalid && axiRsp.arready)
            axiReq.arvalid <= 1'b0;
         done = (axiRsp.rvalid === 1'b1);
      end
      d = axiRsp.rdata;
      resp = axiRsp.rresp;
      axiReq.rready <= 1'b0;
   endtask
endmodule

// ===== dv/tb_uart_reset_and_baud_divisor.sv
// self-checking bench for the uart reset defaults and baud divisor
// assumes urb_host_model as register master and a 250 MHz sys_clk
`timescale 1ns/1ps
module tb_uart_reset_and_baud_divisor;
   logic sys_clk;
   logic rst = 1'b1;
   urb_pkg::urb_axi_req_t axiReq;
   urb_pkg::urb_axi_rsp_t axiRsp;
   urb_pkg::urb_modem_in_t modemIn = 4'hF;
   logic txd, rtsN, dtrN, softRstOut, uartInt, uartIntOeN, irq;
   int err_count = 0;
   int n_tests = 0;
   int shadow[10];
   int d;
   logic [31:0] seed = 32'hfaf3_d122;
   logic [31:0] got;
   logic [1:0] resp;
   logic [7:0] ch;
   logic [7:0] divs [2] = '{8'h01, 8'h03};

   urb_uart dut (.sys_clk(sys_clk), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp), .modemIn(modemIn),
      .txd(txd), .rtsN(rtsN), .dtrN(dtrN), .softRstOut(softRstOut), .uartInt(uartInt),
      .uartIntOeN(uartIntOeN), .irq(irq));
   urb_host_model host (.sys_clk(sys_clk), .axiReq(axiReq), .axiRsp(axiRsp));

   // free running 4 ns clock
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // modem status upper nibble is the complement of the pins
   function automatic logic [31:0] msr_exp();
      return {24'h00_0000, ~modemIn.dcdN, ~modemIn.riN, ~modemIn.dsrN, ~modemIn.ctsN, 4'h0};
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk_span(input int n, input int lo, input int hi);
      n_tests++;
      if (n < lo || n > hi)
      begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
      end
   endtask

   task automatic reg_wr(input logic [3:0] idx, input logic [7:0] v);
      host.wr(idx, v, resp);
      chk(32'(resp), 32'(urb_pkg::URB_RESP_OKAY));
      shadow[idx] = v;
   endtask

   task automatic reg_rd(input logic [3:0] idx, input logic [31:0] e, input logic [1:0] er = 2'h0);
      host.rd(idx, got, resp);
      chk(got, e);
      chk(32'(resp), 32'(er));
   endtask

   // reset held four cycles; pin levels looked at while it is still applied
   task automatic do_reset();
      rst <= 1'b1;
      modemIn <= urb_pkg::urb_modem_in_t'(4'(rnd()));
      repeat (4) @(posedge sys_clk);
      chk({28'h000_0000, txd, softRstOut, rtsN, dtrN}, 32'h0000_000F); // idle reset pins
      chk(32'({uartIntOeN, uartInt}), 32'h0000_0002); // interrupt pin floated, level low
      rst <= 1'b0;
      foreach (shadow[i])
         shadow[i] = 0;
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // watchdog, far beyond the thousand or so cycles the sequence needs
   initial
   begin
      #160000;
      err_count++;
      end_sim();
   end

   // main sequence
   initial
   begin
      do_reset();
      reg_wr(urb_pkg::URB_IDX_IER, 8'h0F);
      reg_wr(urb_pkg::URB_IDX_LCR, 8'h1B);
      reg_wr(urb_pkg::URB_IDX_MCR, 8'h0B);
      repeat (2) @(posedge sys_clk);
      chk({29'h0000_0000, rtsN, dtrN, uartIntOeN}, 32'h0000_0000); // pins follow control
      do_reset(); // second reset in mid-run
      reg_rd(urb_pkg::URB_IDX_IER, 32'(shadow[1])); // enables cleared
      reg_rd(urb_pkg::URB_IDX_ISR, 32'h0000_0001); // nothing pending
      reg_rd(urb_pkg::URB_IDX_LCR, 32'(shadow[3])); // format cleared
      reg_rd(urb_pkg::URB_IDX_MCR, 32'(shadow[4])); // modem control cleared
      reg_rd(urb_pkg::URB_IDX_LSR, 32'h0000_0060); // transmitter empty
      reg_rd(urb_pkg::URB_IDX_MSR, msr_exp()); // no changes, live pins
      chk(32'(uartIntOeN), 32'h0000_0001); // floated with control bit 3 low
      // divisor latch overlays data and enable words
      reg_wr(urb_pkg::URB_IDX_LCR, 8'h83); // open latch
      reg_wr(urb_pkg::URB_IDX_DATA, 8'hA5);
      reg_wr(urb_pkg::URB_IDX_IER, 8'h3C);
      reg_rd(urb_pkg::URB_IDX_DATA, 32'h0000_00A5); // low divisor byte
      reg_rd(urb_pkg::URB_IDX_IER, 32'h0000_003C); // high divisor byte
      reg_wr(urb_pkg::URB_IDX_LCR, 8'h03); // host closes latch
      reg_rd(urb_pkg::URB_IDX_IER, 32'h0000_0000); // enable word is back
      // one random 8-bit frame per divisor, with the event interrupt
      foreach (divs[i])
      begin
         d = divs[i];
         reg_wr(urb_pkg::URB_IDX_LCR, 8'h83);
         reg_wr(urb_pkg::URB_IDX_DATA, divs[i]);
         reg_wr(urb_pkg::URB_IDX_IER, 8'h00);
         reg_wr(urb_pkg::URB_IDX_LCR, 8'h03);
         reg_wr(urb_pkg::URB_IDX_MASK, 8'h01);
         ch = 8'(rnd());
         reg_wr(urb_pkg::URB_IDX_DATA, ch);
         got = 0;
         while (txd === 1'b1 && got < 2000)
         begin
            @(posedge sys_clk);
            got++;
         end
         chk_span(int'(got), 8 * d - 2, 24 * d + 2); // start bit delay
         repeat (8 * d) @(posedge sys_clk);
         chk(32'(txd), 32'h0000_0000); // middle of start bit
         for (int b = 0; b < 8; b++)
         begin
            repeat (16 * d) @(posedge sys_clk);
            chk(32'(txd), 32'(ch[b])); // bit spacing of sixteen ticks
         end
         repeat (16 * d) @(posedge sys_clk);
         chk(32'(txd), 32'h0000_0001);
         chk(32'(irq), 32'h0000_0001);
         reg_wr(urb_pkg::URB_IDX_MASK, 8'h00);
         repeat (2) @(posedge sys_clk);
         chk(32'(irq), 32'h0000_0000);
         repeat (16 * d) @(posedge sys_clk);
         reg_rd(urb_pkg::URB_IDX_STAT, 32'h0000_0003);
         reg_wr(urb_pkg::URB_IDX_MASK, 8'h07);
         repeat (2) @(posedge sys_clk);
         chk(32'(irq), 32'h0000_0000);
      end
      // a clear-to-send change sets its change bit until read
      modemIn <= urb_pkg::urb_modem_in_t'(modemIn ^ 4'b1000);
      repeat (3) @(posedge sys_clk);
      reg_rd(urb_pkg::URB_IDX_MSR, msr_exp() | 32'h0000_0001); // change bit set
      reg_rd(urb_pkg::URB_IDX_MSR, msr_exp()); // read cleared it
      // unmapped word
      reg_rd(4'hA, 32'h0000_0000, urb_pkg::URB_RESP_SLVERR);
      host.wr(4'hA, 8'h55, resp);
      chk(32'(resp), 32'(urb_pkg::URB_RESP_SLVERR));
      end_sim();
   end
endmodule
